// ===== aum_regs.svh
// Timing counts, register map and field positions of the four-port AUI multiplexer.
// Assumes a 100 MHz core clock; all counts are derived from it.
// Functional notes
// - MAU receive data fans out to all DTEs
// - Squelch rejects activity shorter than 20 ns
// - Receive stays active until idle exceeds 180 ns
// - Any DTE transmit data repeats to MAU
// - DTE transmit must pass squelch qualification first
// - Attached MAU loops data back to receivers
// - Grounded receive indicator pin selects local loopback
// - MAU collision drives every DTE collision output
// - Collision signal is 10 MHz square tone
// - Multiple transmitters: collide all, jam MAU 5 MHz
// - Collision asserts within 200 ns, drops within 500
// - About 1 us SQE burst on transmitting port
// - SQE starts 0.6-1.6 us, lasts 0.5-1.5 us
// - No SQE burst on a jabbering port
// - Per-port active-low SQE enable input
// - Jabber timer runs per packet, clears at end
// - Over-long packet disables port, signals its collision
// - Jabber state ends when transmit goes idle
// - Collision tone starts within 100 ns of disable
// - Active-low transmit, jabber, receive, collision indicators
// - Indicators except jabber stretched about 1 ms
// - Timing reference is the device clock
`ifndef AUM_REGS_SVH
`define AUM_REGS_SVH

`define AUM_CLK_NS 10
`define AUM_SQ_ON_NS 20
`define AUM_SQ_ON_CYC ((`AUM_SQ_ON_NS + `AUM_CLK_NS - 1) / `AUM_CLK_NS)
`define AUM_SQ_OFF_NS 180
`define AUM_SQ_OFF_CYC (`AUM_SQ_OFF_NS / `AUM_CLK_NS + 1)
`define AUM_TONE_HALF_NS 50
`define AUM_TONE_HALF_CYC (`AUM_TONE_HALF_NS / `AUM_CLK_NS)
`define AUM_SQE_DLY_NS 900
`define AUM_SQE_DLY_CYC (`AUM_SQE_DLY_NS / `AUM_CLK_NS)
`define AUM_SQE_LEN_NS 1000
`define AUM_SQE_LEN_CYC (`AUM_SQE_LEN_NS / `AUM_CLK_NS)
`define AUM_JAB_US 13500
`define AUM_JAB_CYC (`AUM_JAB_US * 1000 / `AUM_CLK_NS)
`define AUM_LED_US 1000
`define AUM_LED_CYC (`AUM_LED_US * 1000 / `AUM_CLK_NS)

`define AUM_CTRL_OFS 4'h0
`define AUM_STATUS_OFS 4'h4
`define AUM_CTRL_LOOP_BIT 0
`define AUM_CTRL_RST 1'h0
`define AUM_ST_JAB_LSB 0
`define AUM_ST_TXACT_LSB 4
`define AUM_ST_RXACT_BIT 8
`define AUM_ST_COLLISION_LED_N_BIT 9
`define AUM_ST_LOOP_BIT 10

`endif

// ===== aum_pkg.sv
// Types shared by the four-port AUI multiplexer.
// Counter widths here bound the timing parameters of the top module.
package aum_pkg;

  typedef enum logic [1:0] {
    AUM_SQE_IDLE,
    AUM_SQE_WAIT,
    AUM_SQE_BURST
  } aum_sqe_e;

  typedef logic [23:0] aum_cnt_t;

  typedef struct packed {
    logic rx_s1;
    logic rx_s2;
    logic cd_s1;
    logic cd_s2;
    logic rec_s1;
    logic rec_s2;
    logic [1:0] rec_drv_hist;
    logic [3:0] tx_s1;
    logic [3:0] tx_s2;
    logic [3:0] heartbeat_enable_n_s1;
    logic [3:0] heartbeat_enable_n_s2;
    logic rx_act;
    logic [4:0] rx_lo;
    logic [4:0] rx_hi;
    logic cd_act;
    logic [4:0] cd_lo;
    logic [4:0] cd_hi;
    logic [3:0] tx_act;
    logic [3:0][4:0] tx_lo;
    logic [3:0][4:0] tx_hi;
    logic [2:0] tone_div;
    logic tone;
    logic jam;
    logic [3:0] jab;
    aum_cnt_t [3:0] jab_cnt;
    aum_sqe_e [3:0] sqe_st;
    logic [3:0][7:0] sqe_cnt;
    aum_cnt_t rx_led_cnt;
    aum_cnt_t col_led_cnt;
    aum_cnt_t [3:0] tx_led_cnt;
    logic ctrl_loop;
    logic [31:0] rd_data;
    logic [3:0] rx_out;
    logic [3:0] col_out;
    logic tx_out;
  } aum_state_s;

endpackage

// ===== aum_mux.sv
// Control and data steering of a four-DTE to one-MAU AUI multiplexer.
// AUI pairs arrive as single idle-high logic levels from external receivers.
`timescale 1ns/10ps
`include "aum_regs.svh"

module aum_mux #(
  parameter int unsigned JAB_CYC = `AUM_JAB_CYC,
  parameter int unsigned LED_CYC = `AUM_LED_CYC
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // MAU side
  input wire logic mau_receive_in_i,
  input wire logic mau_collision_in_i,
  output logic mau_transmit_out_o,
  // DTE side
  input wire logic [3:0] dte_transmit_in_i,
  output logic [3:0] dte_receive_out_o,
  output logic [3:0] dte_collision_out_o,
  input wire logic [3:0] heartbeat_enable_n_i,
  // Indicators, active low; only the receive indicator is open drain
  input wire logic receive_led_n_i,
  output logic receive_led_n_o,
  output logic receive_led_oe_o,
  output logic collision_led_n_o,
  output logic [3:0] xmit_led_n_o,
  output logic [3:0] babble_led_n_o
);

  localparam logic [4:0] SQ_ON = 5'(`AUM_SQ_ON_CYC);
  localparam logic [4:0] SQ_OFF = 5'(`AUM_SQ_OFF_CYC);
  localparam logic [2:0] TONE_HALF = 3'(`AUM_TONE_HALF_CYC);
  localparam logic [7:0] SQE_DLY = 8'(`AUM_SQE_DLY_CYC);
  localparam logic [7:0] SQE_LEN = 8'(`AUM_SQE_LEN_CYC);
  localparam aum_pkg::aum_cnt_t JAB_LIM = 24'(JAB_CYC);
  localparam aum_pkg::aum_cnt_t LED_LIM = 24'(LED_CYC);

  if (JAB_CYC < 2 || JAB_CYC >= 2 ** 24) begin : g_bad_jab
    $error("JAB_CYC must be 2 .. 2**24-1");
  end
  if (LED_CYC < 1 || LED_CYC >= 2 ** 24) begin : g_bad_led
    $error("LED_CYC must be 1 .. 2**24-1");
  end

  aum_pkg::aum_state_s st_reg;
  aum_pkg::aum_state_s st_next;
  logic loop_w;
  logic multi_w;
  logic collision_led_n_w;
  logic tx_d_w;
  logic rec_drv_w;
  logic [3:0] live_w;

  // Returns {active, low run, high run} after one sample of an idle-high line
  function automatic logic [10:0] sq_step(input logic lvl, input logic act,
                                          input logic [4:0] lo, input logic [4:0] hi);
    logic act_n;
    logic [4:0] lo_n;
    logic [4:0] hi_n;
    act_n = act;
    lo_n = 5'h00;
    hi_n = 5'h00;
    if (!lvl) begin
      lo_n = (lo == 5'h1F) ? lo : lo + 5'h01;
      if (lo_n >= SQ_ON) begin
        act_n = 1'b1;
      end
    end else begin
      hi_n = (hi == 5'h1F) ? hi : hi + 5'h01;
      if (hi_n >= SQ_OFF) begin
        act_n = 1'b0;
      end
    end
    return {act_n, lo_n, hi_n};
  endfunction

  function automatic logic [2:0] count4(input logic [3:0] v);
    return 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]);
  endfunction

  // Stretcher: reload while the event is present, otherwise run down
  function automatic aum_pkg::aum_cnt_t stretch(input logic ev, input aum_pkg::aum_cnt_t c);
    if (ev) begin
      return LED_LIM;
    end
    return (c == 24'h00_0000) ? c : c - 24'h00_0001;
  endfunction

  // Own drive shows up on the pin input two samples late, so recent drive
  // history masks the readback instead of mistaking it for a grounded pin.
  assign rec_drv_w = (st_reg.rx_led_cnt != 24'h00_0000);
  assign loop_w = st_reg.ctrl_loop ||
                  (!st_reg.rec_s2 && !rec_drv_w && st_reg.rec_drv_hist == 2'h0);
  assign live_w = st_reg.tx_act & ~st_reg.jab;
  assign multi_w = (count4(live_w) >= 3'h2);
  assign collision_led_n_w = st_reg.cd_act || multi_w;
  assign tx_d_w = (count4(live_w) == 3'h1) ? |(live_w & st_reg.tx_s2) : 1'b1;

  always_comb begin
    st_next = st_reg;
    st_next.rx_s1 = mau_receive_in_i;
    st_next.rx_s2 = st_reg.rx_s1;
    st_next.cd_s1 = mau_collision_in_i;
    st_next.cd_s2 = st_reg.cd_s1;
    st_next.rec_s1 = receive_led_n_i;
    st_next.rec_s2 = st_reg.rec_s1;
    st_next.rec_drv_hist = {st_reg.rec_drv_hist[0], rec_drv_w};
    st_next.tx_s1 = dte_transmit_in_i;
    st_next.tx_s2 = st_reg.tx_s1;
    st_next.heartbeat_enable_n_s1 = heartbeat_enable_n_i;
    st_next.heartbeat_enable_n_s2 = st_reg.heartbeat_enable_n_s1;

    {st_next.rx_act, st_next.rx_lo, st_next.rx_hi} =
      sq_step(st_reg.rx_s2, st_reg.rx_act, st_reg.rx_lo, st_reg.rx_hi);
    {st_next.cd_act, st_next.cd_lo, st_next.cd_hi} =
      sq_step(st_reg.cd_s2, st_reg.cd_act, st_reg.cd_lo, st_reg.cd_hi);

    // Tone at 10 MHz; jam toggles on each tone rise, giving 5 MHz
    if (st_reg.tone_div == TONE_HALF - 3'h1) begin
      st_next.tone_div = 3'h0;
      st_next.tone = ~st_reg.tone;
      if (!st_reg.tone) begin
        st_next.jam = ~st_reg.jam;
      end
    end else begin
      st_next.tone_div = st_reg.tone_div + 3'h1;
    end

    for (int i = 0; i < 4; i++) begin
      {st_next.tx_act[i], st_next.tx_lo[i], st_next.tx_hi[i]} =
        sq_step(st_reg.tx_s2[i], st_reg.tx_act[i], st_reg.tx_lo[i], st_reg.tx_hi[i]);

      if (!st_reg.tx_act[i]) begin
        st_next.jab[i] = 1'b0;
        st_next.jab_cnt[i] = 24'h00_0000;
      end else if (!st_reg.jab[i]) begin
        if (st_reg.jab_cnt[i] == JAB_LIM - 24'h00_0001) begin
          st_next.jab[i] = 1'b1;
          st_next.jab_cnt[i] = 24'h00_0000;
        end else begin
          st_next.jab_cnt[i] = st_reg.jab_cnt[i] + 24'h00_0001;
        end
      end

      case (st_reg.sqe_st[i])
        aum_pkg::AUM_SQE_IDLE: begin
          if (st_reg.tx_act[i] && !st_next.tx_act[i] && !st_reg.jab[i] &&
              !st_reg.heartbeat_enable_n_s2[i]) begin
            st_next.sqe_st[i] = aum_pkg::AUM_SQE_WAIT;
            st_next.sqe_cnt[i] = 8'h00;
          end
        end
        aum_pkg::AUM_SQE_WAIT: begin
          if (st_reg.tx_act[i]) begin
            st_next.sqe_st[i] = aum_pkg::AUM_SQE_IDLE;
          end else if (st_reg.sqe_cnt[i] == SQE_DLY - 8'h01) begin
            st_next.sqe_st[i] = aum_pkg::AUM_SQE_BURST;
            st_next.sqe_cnt[i] = 8'h00;
          end else begin
            st_next.sqe_cnt[i] = st_reg.sqe_cnt[i] + 8'h01;
          end
        end
        aum_pkg::AUM_SQE_BURST: begin
          if (st_reg.tx_act[i] || st_reg.sqe_cnt[i] == SQE_LEN - 8'h01) begin
            st_next.sqe_st[i] = aum_pkg::AUM_SQE_IDLE;
          end else begin
            st_next.sqe_cnt[i] = st_reg.sqe_cnt[i] + 8'h01;
          end
        end
        default: begin
          st_next.sqe_st[i] = aum_pkg::AUM_SQE_IDLE;
        end
      endcase

      // Jabber forces the tone on its own port from the next cycle
      st_next.col_out[i] = (collision_led_n_w || st_reg.jab[i] ||
                            st_reg.sqe_st[i] == aum_pkg::AUM_SQE_BURST) ?
                           st_reg.tone : 1'b1;
      st_next.tx_led_cnt[i] = stretch(st_reg.tx_act[i], st_reg.tx_led_cnt[i]);
    end

    st_next.rx_led_cnt = stretch(st_reg.rx_act, st_reg.rx_led_cnt);
    st_next.col_led_cnt = stretch(collision_led_n_w, st_reg.col_led_cnt);

    if (loop_w) begin
      st_next.rx_out = {4{tx_d_w}};
    end else begin
      st_next.rx_out = st_reg.rx_act ? {4{st_reg.rx_s2}} : 4'hF;
    end
    st_next.tx_out = multi_w ? st_reg.jam : tx_d_w;

    if (reg_wr_i && reg_addr_i == `AUM_CTRL_OFS) begin
      st_next.ctrl_loop = reg_wdata_i[`AUM_CTRL_LOOP_BIT];
    end
    st_next.rd_data = 32'h0000_0000;
    if (reg_rd_i) begin
      if (reg_addr_i == `AUM_CTRL_OFS) begin
        st_next.rd_data[`AUM_CTRL_LOOP_BIT] = st_reg.ctrl_loop;
      end else if (reg_addr_i == `AUM_STATUS_OFS) begin
        st_next.rd_data[`AUM_ST_JAB_LSB +: 4] = st_reg.jab;
        st_next.rd_data[`AUM_ST_TXACT_LSB +: 4] = st_reg.tx_act;
        st_next.rd_data[`AUM_ST_RXACT_BIT] = st_reg.rx_act;
        st_next.rd_data[`AUM_ST_COLLISION_LED_N_BIT] = collision_led_n_w;
        st_next.rd_data[`AUM_ST_LOOP_BIT] = loop_w;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
      st_reg.rx_s1 <= 1'b1;
      st_reg.rx_s2 <= 1'b1;
      st_reg.cd_s1 <= 1'b1;
      st_reg.cd_s2 <= 1'b1;
      st_reg.rec_s1 <= 1'b1;
      st_reg.rec_s2 <= 1'b1;
      st_reg.tx_s1 <= 4'hF;
      st_reg.tx_s2 <= 4'hF;
      st_reg.heartbeat_enable_n_s1 <= 4'hF;
      st_reg.heartbeat_enable_n_s2 <= 4'hF;
      st_reg.ctrl_loop <= `AUM_CTRL_RST;
      st_reg.rx_out <= 4'hF;
      st_reg.col_out <= 4'hF;
      st_reg.tx_out <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata_o = st_reg.rd_data;
  assign mau_transmit_out_o = st_reg.tx_out;
  assign dte_receive_out_o = st_reg.rx_out;
  assign dte_collision_out_o = st_reg.col_out;
  assign receive_led_n_o = 1'b0;
  assign receive_led_oe_o = rec_drv_w;
  assign collision_led_n_o = (st_reg.col_led_cnt == 24'h00_0000);
  assign babble_led_n_o = ~st_reg.jab;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      xmit_led_n_o[i] = (st_reg.tx_led_cnt[i] == 24'h00_0000);
    end
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_short_low;
    !st_reg.rx_act && !st_reg.rx_s2 && st_reg.rx_lo == 5'h00 ##1 st_reg.rx_s2;
  endsequence
  sequence s_sqe_arm;
    $fell(st_reg.tx_act[0]) && !$past(st_reg.jab[0]) && !$past(st_reg.heartbeat_enable_n_s2[0]);
  endsequence

  property p_rx_fanout;
    st_reg.rx_act && !loop_w |=> dte_receive_out_o == {4{$past(st_reg.rx_s2)}};
  endproperty
  a_rx_fanout: assert property (p_rx_fanout) else $error("receive fanout wrong");
  property p_sq_reject;
    s_short_low |=> !st_reg.rx_act;
  endproperty
  a_sq_reject: assert property (p_sq_reject) else $error("short pulse unsquelched");
  property p_sq_hold;
    st_reg.rx_act && !st_reg.rx_s2 |=> st_reg.rx_act [*8];
  endproperty
  a_sq_hold: assert property (p_sq_hold) else $error("receive dropped early");
  property p_tx_repeat;
    live_w == 4'b0001 |=> mau_transmit_out_o == $past(st_reg.tx_s2[0]);
  endproperty
  a_tx_repeat: assert property (p_tx_repeat) else $error("transmit not repeated");
  property p_tx_qual;
    live_w == 4'h0 |=> mau_transmit_out_o;
  endproperty
  a_tx_qual: assert property (p_tx_qual) else $error("unqualified transmit");
  property p_loop;
    loop_w && live_w == 4'b0010 |=> dte_receive_out_o == {4{$past(st_reg.tx_s2[1])}};
  endproperty
  a_loop: assert property (p_loop) else $error("loopback data wrong");
  property p_collision_led_n_fan;
    st_reg.cd_act |=> dte_collision_out_o == {4{$past(st_reg.tone)}};
  endproperty
  a_collision_led_n_fan: assert property (p_collision_led_n_fan) else $error("collision not fanned");
  property p_tone;
    $rose(st_reg.tone) |-> st_reg.tone [*5] ##1 !st_reg.tone;
  endproperty
  a_tone: assert property (p_tone) else $error("tone period wrong");
  property p_jam;
    multi_w |=> mau_transmit_out_o == $past(st_reg.jam) && dte_collision_out_o == {4{$past(st_reg.tone)}};
  endproperty
  a_jam: assert property (p_jam) else $error("jam or collision missing");
  property p_sqe_start;
    s_sqe_arm |-> ##[85:95] st_reg.sqe_st[0] == aum_pkg::AUM_SQE_BURST || st_reg.tx_act[0];
  endproperty
  a_sqe_start: assert property (p_sqe_start) else $error("SQE burst late");
  // Port 1 is the one that can be driven into jabber in practice
  property p_sqe_jab;
    $fell(st_reg.tx_act[1]) && $past(st_reg.jab[1]) |-> st_reg.sqe_st[1] == aum_pkg::AUM_SQE_IDLE [*8];
  endproperty
  a_sqe_jab: assert property (p_sqe_jab) else $error("SQE after jabber");
  property p_sqe_off;
    $fell(st_reg.tx_act[3]) && $past(st_reg.heartbeat_enable_n_s2[3]) |-> st_reg.sqe_st[3] == aum_pkg::AUM_SQE_IDLE [*8];
  endproperty
  a_sqe_off: assert property (p_sqe_off) else $error("SQE not disabled");
  // The flag may clear one cycle after idle, so the LED is checked in the flag's own cycle
  property p_jab_col;
    st_reg.jab[1] |-> !babble_led_n_o[1] ##1 dte_collision_out_o[1] == $past(st_reg.tone);
  endproperty
  a_jab_col: assert property (p_jab_col) else $error("jabber collision missing");
  property p_jab_exit;
    !st_reg.tx_act[1] |=> !st_reg.jab[1];
  endproperty
  a_jab_exit: assert property (p_jab_exit) else $error("jabber held on idle");
  property p_led;
    st_reg.tx_act[1] |=> !xmit_led_n_o[1] [*8];
  endproperty
  a_led: assert property (p_led) else $error("transmit LED not stretched");

endmodule

// ===== aum_far_model.sv
// Far-side model: four DTE stations and one MAU, every line idle high.
// Assumes the bench raises one request bit per line; a live line sends 5 low, 5 high cycles.
`timescale 1ns/10ps

module aum_far_model (
  // Clock and control
  input wire logic core_clk_i,
  input wire logic [5:0] req_i,
  input wire logic loop_i,
  input wire logic mau_transmit_out_i,
  // Lines toward the multiplexer
  output logic [3:0] dte_transmit_in_o,
  output logic mau_receive_in_o,
  output logic mau_collision_in_o
);
  logic [5:0][3:0] ph_reg;
  logic loop_reg;
  logic [5:0] lvl;

  always_ff @(posedge core_clk_i) begin
    loop_reg <= mau_transmit_out_i;
    for (int k = 0; k < 6; k++) begin
      ph_reg[k] <= (!req_i[k] || ph_reg[k] == 4'h9) ? 4'h0 : ph_reg[k] + 4'h1;
    end
  end

  // A released line falls back to its idle bias, never to the last driven value
  always_comb begin
    for (int k = 0; k < 6; k++) begin
      lvl[k] = !(req_i[k] && ph_reg[k] < 4'h5);
    end
  end

  assign dte_transmit_in_o = lvl[3:0];
  assign mau_receive_in_o = lvl[4] & (loop_i ? loop_reg : 1'b1);
  assign mau_collision_in_o = lvl[5];
endmodule

// ===== aum_mux_bench.sv
// Self-checking bench for the four-port AUI multiplexer.
// Assumes aum_far_model drives the AUI lines; jabber and LED timers are shortened.
`timescale 1ns/10ps

module aum_mux_bench;
  localparam int JAB = 200;
  localparam int LED = 50;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic mau_receive_in_i, mau_collision_in_i, mau_transmit_out_o;
  logic [3:0] dte_transmit_in_i, dte_receive_out_o, dte_collision_out_o;
  logic [3:0] heartbeat_enable_n_i = 4'h8;
  logic receive_led_n_i, receive_led_n_o, receive_led_oe_o, collision_led_n_o;
  logic [3:0] xmit_led_n_o, babble_led_n_o;
  logic [5:0] req = 6'h00;
  logic loop_en = 1'b0;
  logic gnd = 1'b0;
  logic [31:0] rdat;
  logic [3:0] rx_lo, col_lo;
  logic tx_lo;
  int tx_edg, col_edg, first, last, split, fail_count, checks, p;

  initial begin
    forever #5 core_clk_i = ~core_clk_i;
  end

  // Open-drain indicator pin: grounded by the board or pulled low by the LED driver
  assign receive_led_n_i = gnd ? 1'b0 : (receive_led_oe_o ? receive_led_n_o : 1'b1);

  aum_mux #(.JAB_CYC(JAB), .LED_CYC(LED)) uut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .mau_receive_in_i(mau_receive_in_i),
    .mau_collision_in_i(mau_collision_in_i), .mau_transmit_out_o(mau_transmit_out_o),
    .dte_transmit_in_i(dte_transmit_in_i), .dte_receive_out_o(dte_receive_out_o),
    .dte_collision_out_o(dte_collision_out_o), .heartbeat_enable_n_i(heartbeat_enable_n_i),
    .receive_led_n_i(receive_led_n_i), .receive_led_n_o(receive_led_n_o),
    .receive_led_oe_o(receive_led_oe_o), .collision_led_n_o(collision_led_n_o),
    .xmit_led_n_o(xmit_led_n_o), .babble_led_n_o(babble_led_n_o));

  aum_far_model far (.core_clk_i(core_clk_i), .req_i(req), .loop_i(loop_en),
    .mau_transmit_out_i(mau_transmit_out_o), .dte_transmit_in_o(dte_transmit_in_i),
    .mau_receive_in_o(mau_receive_in_i), .mau_collision_in_o(mau_collision_in_i));

  task automatic print_verdict();
    $display("compares %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    rdat = reg_rdata_o;
  endtask

  task automatic send(input logic [5:0] w, input int n);
    @(posedge core_clk_i);
    req <= w;
    repeat (n) @(posedge core_clk_i);
    req <= 6'h00;
    #1;
  endtask

  // Watches n cycles: which outputs went low, edge counts, low span on one collision pair
  task automatic scan(input int n, input int sel);
    logic ptx, pcol;
    rx_lo = 4'h0;
    col_lo = 4'h0;
    tx_lo = 1'b0;
    tx_edg = 0;
    col_edg = 0;
    split = 0;
    first = -1;
    last = -1;
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk_i);
      #1;
      rx_lo |= ~dte_receive_out_o;
      col_lo |= ~dte_collision_out_o;
      tx_lo |= ~mau_transmit_out_o;
      if (dte_receive_out_o != 4'h0 && dte_receive_out_o != 4'hf) split = 1;
      if (i > 0 && mau_transmit_out_o !== ptx) tx_edg++;
      if (i > 0 && dte_collision_out_o[sel] !== pcol) col_edg++;
      if (dte_collision_out_o[sel] === 1'b0) begin
        if (first < 0) first = i;
        last = i;
      end
      ptx = mau_transmit_out_o;
      pcol = dte_collision_out_o[sel];
    end
  endtask

  initial begin
    repeat (20000) @(posedge core_clk_i);
    fail_count++;
    print_verdict();
  end

  initial begin
    repeat (4) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    @(posedge core_clk_i);
    #1;
    chk({mau_transmit_out_o, dte_receive_out_o, dte_collision_out_o, collision_led_n_o,
      xmit_led_n_o, babble_led_n_o, receive_led_oe_o}, 32'h0007_fffe);
    chk(reg_rdata_o, 32'h0000_0000);
    wr(4'h0, 32'h0000_0001);
    rd(4'h0);
    chk(rdat, 32'h0000_0001);
    rd(4'h8);
    chk(rdat, 32'h0000_0000);
    // Forced loopback by control bit, then by the grounded indicator pin
    for (p = 0; p < 2; p++) begin
      if (p == 1) @(posedge core_clk_i) gnd <= 1'b1;
      fork
        send(6'h04, 60);
        scan(50, 0);
      join
      chk(rx_lo, 4'hf);
      wr(4'h0, 32'h0000_0000);
      @(posedge core_clk_i) gnd <= 1'b0;
      scan(300, 0);
    end
    fork
      send(6'h10, 60);
      scan(50, 0);
    join
    chk(rx_lo, 4'hf);
    chk(split, 0);
    chk(receive_led_oe_o, 1'b1);
    rd(4'h4);
    chk(rdat[8], 1'b1);
    scan(40, 0);
    rd(4'h4);
    chk(rdat[8], 1'b0);
    chk(receive_led_oe_o, 1'b1);
    scan(60, 0);
    chk(receive_led_oe_o, 1'b0);
    send(6'h10, 1);
    scan(20, 0);
    chk(rx_lo, 4'h0);
    send(6'h01, 1);
    scan(20, 0);
    chk(tx_lo, 1'b0);
    // Each port alone; the heartbeat of port 3 is switched off
    for (p = 0; p < 4; p++) begin
      fork
        send(6'h01 << p, 60);
        scan(50, p);
      join
      chk(tx_lo, 1'b1);
      chk(col_lo, 4'h0);
      chk(xmit_led_n_o[p], 1'b0);
      scan(300, p);
      chk(col_lo & ~(4'h1 << p), 4'h0);
      chk(first >= 54 && first <= 154, p != 3);
      chk(last - first >= 45 && last - first <= 150, p != 3);
    end
    // Two DTEs at once, then a collision reported by the MAU
    for (p = 0; p < 2; p++) begin
      fork
        send(p == 0 ? 6'h03 : 6'h20, 100);
        begin
          scan(20, 0);
          chk(col_lo, 4'hf);
          scan(40, 0);
          chk(tx_edg >= 3 && tx_edg <= 5, p == 0);
          chk(col_edg >= 7 && col_edg <= 9, 1'b1);
        end
      join
      chk(collision_led_n_o, 1'b0);
      scan(70, 0);
      scan(25, 0);
      chk(col_lo, 4'h0);
      scan(300, 0);
    end
    @(posedge core_clk_i) loop_en <= 1'b1;
    fork
      send(6'h01, 60);
      scan(50, 0);
    join
    chk(rx_lo, 4'hf);
    chk(receive_led_oe_o, 1'b1);
    @(posedge core_clk_i) loop_en <= 1'b0;
    scan(300, 0);
    fork
      send(6'h02, 400);
      begin
        scan(250, 1);
        chk(first >= JAB && first <= JAB + 15, 1'b1);
        chk(babble_led_n_o, 4'hd);
        scan(100, 1);
        chk(tx_lo, 1'b0);
        chk(col_lo, 4'h2);
      end
    join
    rd(4'h4);
    chk(rdat[3:0], 4'h2);
    scan(60, 1);
    chk(babble_led_n_o, 4'hf);
    scan(250, 1);
    chk(col_lo, 4'h0);
    send(6'h01, 150);
    scan(40, 0);
    send(6'h01, 150);
    chk(babble_led_n_o[0], 1'b1);
    print_verdict();
  end
endmodule
